//--- dwf_pkg.sv
// Package for the decrement, watchdog-clear and flash instruction executor.
// Assumes a single 20 MHz core clock shared by all users of these definitions.
`default_nettype none
package dwf_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam logic [15:0] OPC_WDT_CLEAR = 16'h0004;
  localparam logic [15:0] OPC_FLASH_ERASE = 16'h0003;
  localparam logic [15:0] OPC_FLASH_READ = 16'h001b;
  localparam logic [15:0] OPC_FLASH_PROG = 16'h001a;
  localparam logic [6:0] OPC_DEC = 7'h07;
  localparam logic [6:0] OPC_DEC_ACC = 7'h06;
  localparam logic [6:0] OPC_DSNZ = 7'h27;
  localparam logic [6:0] OPC_DSNZ_ACC = 7'h26;
  localparam logic [6:0] OPC_DSZ = 7'h17;
  localparam logic [6:0] OPC_DSZ_ACC = 7'h16;
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC_LO = 9;
  localparam int unsigned ADDR_W = 9;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] FLASH_ADDRX_LAST = 8'h01;
  localparam int unsigned FLASH_WORD_AW = 16;
  localparam int unsigned ERASE_WORDS = 256;
  localparam int unsigned ERASE_IDX_W = 8;
  localparam int unsigned FLASH_WORDS = 131072;
  localparam int unsigned FLASH_ACCESS_CYC = 4;
  localparam int unsigned FLASH_CNT_W = 9;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  typedef enum logic [1:0] {
    DWF_FL_NONE,
    DWF_FL_ERASE,
    DWF_FL_READ,
    DWF_FL_PROG
  } dwf_flop_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] middle;
    logic [7:0] low;
  } dwf_addr_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dwf_data_t;

  typedef struct packed {
    logic we;
    logic [FLASH_WORD_AW:0] addr;
    logic [15:0] wdata;
  } dwf_mem_req_t;
endpackage
`default_nettype wire

//--- dwf_flash_mem.sv
// Program flash word array with a registered read port.
// Assumes one request at a time from the executor and a single core clock.
`default_nettype none
module dwf_flash_mem
  import dwf_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire dwf_pkg::dwf_mem_req_t req,
  input wire logic req_valid,
  output logic [15:0] rdata_q
);
  logic [15:0] mem [FLASH_WORDS];
  always_ff @(posedge clk) begin
    if (ce && req_valid) begin
      if (req.we) begin
        mem[req.addr] <= req.wdata;
      end
      rdata_q <= mem[req.addr];
    end
  end
endmodule
`default_nettype wire

//--- dwf_flash_seq.sv
// Flash operation sequencer: holds the busy flag and drives the array.
// Assumes requests arrive only while idle, as software must guarantee.
`default_nettype none
module dwf_flash_seq
  import dwf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire dwf_pkg::dwf_flop_t start_op,
  input wire dwf_pkg::dwf_addr_t addr,
  input wire dwf_pkg::dwf_data_t wdata,
  output logic busy_q,
  output logic done_q,
  output dwf_pkg::dwf_mem_req_t req_q,
  output logic req_valid_q
);
  import dwf_pkg::*;
  localparam logic [FLASH_CNT_W-1:0] ACC_CYC = FLASH_CNT_W'(FLASH_ACCESS_CYC);
  localparam logic [FLASH_CNT_W-1:0] ERASE_CYC = FLASH_CNT_W'(ERASE_WORDS);
  dwf_flop_t op_q;
  logic [FLASH_CNT_W-1:0] cnt_q;
  logic [ERASE_IDX_W-1:0] eidx_q;
  logic in_flash;
  logic start;
  logic last;
  assign in_flash = addr.upper <= FLASH_ADDRX_LAST;
  assign start = (start_op != DWF_FL_NONE) && !busy_q && in_flash;
  assign last = busy_q && (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      op_q <= DWF_FL_NONE;
      cnt_q <= '0;
      eidx_q <= '0;
      req_q <= '0;
      req_valid_q <= 1'b0;
    end else if (ce) begin
      done_q <= last;
      req_valid_q <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        op_q <= start_op;
        cnt_q <= (start_op == DWF_FL_ERASE) ? ERASE_CYC : ACC_CYC;
        eidx_q <= '0;
        req_valid_q <= (start_op != DWF_FL_ERASE);
        req_q.we <= (start_op == DWF_FL_PROG);
        req_q.addr <= {1'b0, addr.upper[0], addr.middle, addr.low[7:1]};
        req_q.wdata <= {wdata.high, wdata.low};
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
        if (last) begin
          busy_q <= 1'b0;
        end
        if (op_q == DWF_FL_ERASE && cnt_q != '0) begin
          req_valid_q <= 1'b1;
          req_q.we <= 1'b1;
          // The block base is taken from the latched address, so software may reload it mid-erase.
          req_q.addr <= {1'b0, req_q.addr[FLASH_WORD_AW-1:ERASE_IDX_W], eidx_q};
          req_q.wdata <= ERASED_WORD;
          eidx_q <= eidx_q + 1'b1;
        end
      end
    end
  end

  property p_busy_ends;
    @(posedge clk) disable iff (reset) $rose(busy_q) |-> ##[1:300] !busy_q;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("flash op never finished");
endmodule
`default_nettype wire

//--- dwf_exec.sv
// Executor for decrement, watchdog-clear and flash instructions of the core.
// Assumes the decoder presents one instruction with its operand value each enabled cycle.
`default_nettype none
// Overview of operation
// - Watchdog clear pulses wdt_clear_q for one cycle.
// - Decrement register in place, wrap, set zero.
// - Decrement into accumulator, register kept, zero flag.
// - In-place decrement, skip when result nonzero.
// - Accumulator decrement, skip when result nonzero.
// - Skip forms take one or two cycles.
// - In-place decrement, skip when result zero.
// - Accumulator decrement, skip when result zero.
// - Erase a 512-byte block at middle address.
// - Read flash word into data bytes.
// - Program data bytes into flash word.
// - Flash instructions with upper address within flash set pending flag; clears when done.
// - Flash inaccessible while sequencer busy; pending flag clears one cycle later.
module dwf_exec
  import dwf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] operand_value,
  input wire dwf_pkg::dwf_addr_t flash_addr,
  input wire dwf_pkg::dwf_data_t data_in,
  output logic [7:0] accum_q,
  output logic [7:0] reg_wdata_q,
  output logic [ADDR_W-1:0] reg_waddr_q,
  output logic reg_we_q,
  output logic zero_flag_q,
  output logic wdt_clear_q,
  output logic skip_next_q,
  output logic stall_q,
  output logic flash_op_pending,
  output logic extended_config_reg_busy_q,
  output dwf_pkg::dwf_data_t data_out_q,
  output logic data_out_we_q
);
  import dwf_pkg::*;

  function automatic logic is_op(input logic [15:0] ins, input logic [6:0] opc);
    return ins[OPC_HI:OPC_LO] == opc;
  endfunction

  logic [7:0] dec_val;
  logic dec_zero;
  logic op_dec, op_dec_acc, op_dsnz, op_dsnz_acc, op_dsz, op_dsz_acc;
  logic op_wdt, op_erase, op_read, op_prog;
  logic to_reg, to_acc, set_z, do_skip, any_dec;
  logic fl_busy, fl_done, fl_rv;
  logic [15:0] fl_rdata;
  dwf_mem_req_t fl_req;
  dwf_flop_t fl_start;
  dwf_flop_t last_op_q;
  logic busy_d;

  assign dec_val = operand_value - BYTE_ONE;
  assign dec_zero = dec_val == BYTE_ZERO;
  assign op_dec = instr_valid && is_op(instr, OPC_DEC);
  assign op_dec_acc = instr_valid && is_op(instr, OPC_DEC_ACC);
  assign op_dsnz = instr_valid && is_op(instr, OPC_DSNZ);
  assign op_dsnz_acc = instr_valid && is_op(instr, OPC_DSNZ_ACC);
  assign op_dsz = instr_valid && is_op(instr, OPC_DSZ);
  assign op_dsz_acc = instr_valid && is_op(instr, OPC_DSZ_ACC);
  assign op_wdt = instr_valid && instr == OPC_WDT_CLEAR;
  assign op_erase = instr_valid && instr == OPC_FLASH_ERASE;
  assign op_read = instr_valid && instr == OPC_FLASH_READ;
  assign op_prog = instr_valid && instr == OPC_FLASH_PROG;
  assign to_reg = op_dec || op_dsnz || op_dsz;
  assign to_acc = op_dec_acc || op_dsnz_acc || op_dsz_acc;
  assign set_z = op_dec || op_dec_acc;
  // The accumulator skip-on-nonzero form skips on a nonzero result, like its in-place twin.
  assign do_skip = ((op_dsnz || op_dsnz_acc) && !dec_zero) || ((op_dsz || op_dsz_acc) && dec_zero);
  assign any_dec = to_reg || to_acc;
  // A second flash request while the sequencer is busy is dropped, keeping the array untouched.
  assign fl_start = fl_busy ? DWF_FL_NONE :
                    op_erase ? DWF_FL_ERASE :
                    op_read ? DWF_FL_READ :
                    op_prog ? DWF_FL_PROG : DWF_FL_NONE;
  assign busy_d = fl_busy;

  dwf_flash_seq u_seq (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start_op(fl_start),
    .addr(flash_addr),
    .wdata(data_in),
    .busy_q(fl_busy),
    .done_q(fl_done),
    .req_q(fl_req),
    .req_valid_q(fl_rv)
  );

  dwf_flash_mem u_mem (
    .clk(clk),
    .ce(ce),
    .req(fl_req),
    .req_valid(fl_rv),
    .rdata_q(fl_rdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      accum_q <= '0;
      reg_wdata_q <= '0;
      reg_waddr_q <= '0;
      reg_we_q <= 1'b0;
      zero_flag_q <= 1'b0;
      wdt_clear_q <= 1'b0;
      skip_next_q <= 1'b0;
      stall_q <= 1'b0;
      flash_op_pending <= 1'b0;
      extended_config_reg_busy_q <= 1'b0;
      data_out_q <= '0;
      data_out_we_q <= 1'b0;
      last_op_q <= DWF_FL_NONE;
    end else if (ce) begin
      wdt_clear_q <= op_wdt;
      reg_we_q <= to_reg;
      reg_wdata_q <= dec_val;
      reg_waddr_q <= instr[ADDR_W-1:0];
      if (to_acc) begin
        accum_q <= dec_val;
      end
      if (set_z) begin
        zero_flag_q <= dec_zero;
      end
      skip_next_q <= do_skip;
      stall_q <= do_skip;
      flash_op_pending <= busy_d || (fl_start != DWF_FL_NONE && flash_addr.upper <= FLASH_ADDRX_LAST);
      extended_config_reg_busy_q <= busy_d || (fl_start != DWF_FL_NONE && flash_addr.upper <= FLASH_ADDRX_LAST);
      if (fl_start != DWF_FL_NONE) begin
        last_op_q <= fl_start;
      end
      data_out_we_q <= fl_done && last_op_q == DWF_FL_READ;
      if (fl_done && last_op_q == DWF_FL_READ) begin
        data_out_q <= {fl_rdata[15:8], fl_rdata[7:0]};
      end
    end
  end

  property p_wdt_one;
    @(posedge clk) disable iff (reset) (ce && op_wdt) |=> wdt_clear_q;
  endproperty
  a_wdt_one: assert property (p_wdt_one) else $error("watchdog clear missing");

  property p_dec_wrap;
    @(posedge clk) disable iff (reset) (ce && op_dec && operand_value == BYTE_ZERO) |=> (reg_wdata_q == 8'hff && reg_we_q && !zero_flag_q);
  endproperty
  a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

  property p_dec_acc;
    @(posedge clk) disable iff (reset) (ce && op_dec_acc) |=> (!reg_we_q && accum_q == $past(operand_value) - 8'h01 && zero_flag_q == (accum_q == 8'h00));
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("accumulator decrement wrong");

  property p_dsnz;
    @(posedge clk) disable iff (reset) (ce && op_dsnz) |=> (skip_next_q == ($past(operand_value) != 8'h01) && $stable(zero_flag_q));
  endproperty
  a_dsnz: assert property (p_dsnz) else $error("skip on nonzero wrong");

  property p_dsnz_acc;
    @(posedge clk) disable iff (reset) (ce && op_dsnz_acc) |=> (!reg_we_q && skip_next_q == (accum_q != 8'h00));
  endproperty
  a_dsnz_acc: assert property (p_dsnz_acc) else $error("accumulator skip nonzero wrong");

  property p_two_cycle;
    @(posedge clk) disable iff (reset) skip_next_q |-> stall_q;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("skip without extra cycle");

  property p_dsz;
    @(posedge clk) disable iff (reset) (ce && op_dsz) |=> (reg_we_q && skip_next_q == (reg_wdata_q == 8'h00));
  endproperty
  a_dsz: assert property (p_dsz) else $error("skip on zero wrong");

  property p_dsz_acc;
    @(posedge clk) disable iff (reset) (ce && op_dsz_acc) |=> (!reg_we_q && skip_next_q == (accum_q == 8'h00));
  endproperty
  a_dsz_acc: assert property (p_dsz_acc) else $error("accumulator skip zero wrong");

  property p_pending_set;
    @(posedge clk) disable iff (reset) (ce && !fl_busy && op_prog && flash_addr.upper <= FLASH_ADDRX_LAST) |=> flash_op_pending;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending flag not set");

  property p_wdt_pulse;
    @(posedge clk) disable iff (reset)
      (ce && !op_wdt) |=> !wdt_clear_q;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear held too long");

  property p_dec_inplace;
    @(posedge clk) disable iff (reset)
      (ce && op_dec) |=> (reg_we_q && reg_wdata_q == $past(operand_value) - 8'h01 && zero_flag_q == (reg_wdata_q == 8'h00));
  endproperty
  a_dec_inplace: assert property (p_dec_inplace) else $error("in-place decrement wrong");

  property p_dec_addr;
    @(posedge clk) disable iff (reset)
      (ce && to_reg) |=> reg_waddr_q == $past(instr[ADDR_W-1:0]);
  endproperty
  a_dec_addr: assert property (p_dec_addr) else $error("write-back address wrong");

  property p_acc_keep;
    @(posedge clk) disable iff (reset)
      (ce && !to_acc) |=> $stable(accum_q);
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("accumulator changed unexpectedly");

  property p_dsnz_write;
    @(posedge clk) disable iff (reset)
      (ce && op_dsnz) |=> (reg_we_q && reg_wdata_q == $past(operand_value) - 8'h01);
  endproperty
  a_dsnz_write: assert property (p_dsnz_write) else $error("skip nonzero write-back wrong");

  property p_dsnz_acc_flag;
    @(posedge clk) disable iff (reset)
      (ce && op_dsnz_acc) |=> ($stable(zero_flag_q) && accum_q == $past(operand_value) - 8'h01);
  endproperty
  a_dsnz_acc_flag: assert property (p_dsnz_acc_flag) else $error("accumulator skip nonzero value wrong");

  property p_one_cycle;
    @(posedge clk) disable iff (reset)
      (ce && any_dec && !do_skip) |=> !stall_q;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("extra cycle without skip");

  property p_skip_pulse;
    @(posedge clk) disable iff (reset)
      (ce && !instr_valid) |=> (!skip_next_q && !stall_q);
  endproperty
  a_skip_pulse: assert property (p_skip_pulse) else $error("skip without instruction");

  property p_dsz_flag;
    @(posedge clk) disable iff (reset)
      (ce && op_dsz) |=> $stable(zero_flag_q);
  endproperty
  a_dsz_flag: assert property (p_dsz_flag) else $error("skip on zero touched flag");

  property p_dsz_acc_val;
    @(posedge clk) disable iff (reset)
      (ce && op_dsz_acc) |=> ($stable(zero_flag_q) && accum_q == $past(operand_value) - 8'h01);
  endproperty
  a_dsz_acc_val: assert property (p_dsz_acc_val) else $error("accumulator skip zero value wrong");

  property p_erase_start;
    @(posedge clk) disable iff (reset)
      (ce && !fl_busy && op_erase && flash_addr.upper <= FLASH_ADDRX_LAST) |=> (fl_busy && flash_op_pending);
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");

  property p_outside;
    @(posedge clk) disable iff (reset)
      (ce && !fl_busy && (op_erase || op_read || op_prog) && flash_addr.upper > FLASH_ADDRX_LAST) |=> !fl_busy;
  endproperty
  a_outside: assert property (p_outside) else $error("outside address started flash");

  property p_read_word;
    @(posedge clk) disable iff (reset)
      data_out_we_q |-> data_out_q == fl_rdata;
  endproperty
  a_read_word: assert property (p_read_word) else $error("read word not delivered");

  property p_pending_mirror;
    @(posedge clk) disable iff (reset)
      flash_op_pending == extended_config_reg_busy_q;
  endproperty
  a_pending_mirror: assert property (p_pending_mirror) else $error("config busy bit differs");

  property p_pending_clears;
    @(posedge clk) disable iff (reset)
      (ce && flash_op_pending && !fl_busy && fl_start == DWF_FL_NONE) |=> !flash_op_pending;
  endproperty
  a_pending_clears: assert property (p_pending_clears) else $error("pending flag stuck");

  property p_no_restart;
    @(posedge clk) disable iff (reset)
      (ce && fl_busy) |-> fl_start == DWF_FL_NONE;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("flash touched while pending");

  property p_freeze;
    @(posedge clk) disable iff (reset)
      !ce |=> ($stable(zero_flag_q) && $stable(flash_op_pending) && $stable(accum_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule
`default_nettype wire

//--- dwf_regs_model.sv
// Register file model behind the executor's operand and write-back ports.
// Assumes the bench preloads cells directly and keeps one write in flight.
`default_nettype none
module dwf_regs_model
  import dwf_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] instr,
  input wire logic [7:0] reg_wdata_q,
  input wire logic [ADDR_W-1:0] reg_waddr_q,
  input wire logic reg_we_q,
  output logic [7:0] operand_value
);
  logic [7:0] mem [2**ADDR_W];
  // The operand follows the address field at once, as the core's register read does.
  assign operand_value = mem[instr[ADDR_W-1:0]];
  always @(posedge clk) begin
    if (reg_we_q) begin
      mem[reg_waddr_q] <= reg_wdata_q;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the decrement, watchdog-clear and flash executor.
// Assumes the register file model and the design files are compiled first.
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dwf_pkg::*;
  logic clk = 0, reset = 1, ce = 1, instr_valid = 0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] operand_value, accum_q, reg_wdata_q;
  logic [ADDR_W-1:0] reg_waddr_q;
  logic reg_we_q, zero_flag_q, wdt_clear_q, skip_next_q, stall_q;
  logic flash_op_pending, extended_config_reg_busy_q, data_out_we_q;
  dwf_addr_t flash_addr = '0;
  dwf_data_t data_in = '0;
  dwf_data_t data_out_q;
  int errors = 0, checks_done = 0;
  int seed = 32'h428f_0e66;
  logic zf = 0;
  logic [23:0] ad;
  logic [15:0] d;
  logic [6:0] opc_tab [6] = '{OPC_DEC, OPC_DEC_ACC, OPC_DSNZ, OPC_DSNZ_ACC, OPC_DSZ, OPC_DSZ_ACC};
  always #25 clk = ~clk;
  dwf_exec dut (.clk(clk), .reset(reset), .ce(ce), .instr_valid(instr_valid), .instr(instr),
    .operand_value(operand_value), .flash_addr(flash_addr), .data_in(data_in), .accum_q(accum_q),
    .reg_wdata_q(reg_wdata_q), .reg_waddr_q(reg_waddr_q), .reg_we_q(reg_we_q),
    .zero_flag_q(zero_flag_q), .wdt_clear_q(wdt_clear_q), .skip_next_q(skip_next_q),
    .stall_q(stall_q), .flash_op_pending(flash_op_pending),
    .extended_config_reg_busy_q(extended_config_reg_busy_q), .data_out_q(data_out_q),
    .data_out_we_q(data_out_we_q));
  dwf_regs_model rf (.clk(clk), .instr(instr), .reg_wdata_q(reg_wdata_q),
    .reg_waddr_q(reg_waddr_q), .reg_we_q(reg_we_q), .operand_value(operand_value));
  function automatic logic skips(input logic [6:0] opc, input logic [7:0] r);
    if (opc == OPC_DSNZ || opc == OPC_DSNZ_ACC) return r != 8'h00;
    if (opc == OPC_DSZ || opc == OPC_DSZ_ACC) return r == 8'h00;
    return 1'b0;
  endfunction
  task automatic dec_op(input logic [6:0] opc, input logic [8:0] a, input logic [7:0] v);
    logic [7:0] r;
    logic ip, sk;
    r = v - 8'h01;
    ip = opc[0];
    sk = skips(opc, r);
    rf.mem[a] = v;
    instr = {opc, a};
    instr_valid = 1;
    @(negedge clk);
    instr_valid = 0;
    if (opc == OPC_DEC || opc == OPC_DEC_ACC) zf = (r == 8'h00);
    `CHK("reg_we", ip, reg_we_q)
    if (!ip) `CHK("accum", r, accum_q)
    `CHK("skip", sk, skip_next_q)
    `CHK("stall", sk, stall_q)
    `CHK("zero", zf, zero_flag_q)
    @(negedge clk);
    `CHK("reg", ip ? r : v, rf.mem[a])
    `CHK("pulse", 1'b0, skip_next_q | reg_we_q)
  endtask
  task automatic fl(input logic [15:0] opc, input logic [23:0] a, input logic [15:0] v);
    int n;
    logic got;
    flash_addr = a;
    data_in = v;
    instr = opc;
    instr_valid = 1;
    @(negedge clk);
    instr_valid = 0;
    `CHK("pending", a[23:16] <= FLASH_ADDRX_LAST, flash_op_pending)
    `CHK("cfg_busy", a[23:16] <= FLASH_ADDRX_LAST, extended_config_reg_busy_q)
    // Other instructions must still run while the flash is busy.
    if (flash_op_pending === 1'b1) dec_op(OPC_DSZ, 9'h010, 8'h01);
    n = 0;
    got = 0;
    while (n < 400 && (flash_op_pending !== 1'b0 || (opc == OPC_FLASH_READ && !got))) begin
      got |= (data_out_we_q === 1'b1);
      n++;
      @(negedge clk);
    end
    `CHK("op_end", 1'b1, n < 400)
  endtask
  task close_out;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    errors++;
    close_out();
  end
  initial begin
    repeat (5) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 6; i++) begin
      dec_op(opc_tab[i], 9'h1ff, 8'h00);
      dec_op(opc_tab[i], 9'h000, 8'h01);
      dec_op(opc_tab[i], 9'h055, 8'h02);
    end
    for (int i = 0; i < 40; i++) dec_op(opc_tab[$unsigned($random(seed)) % 6], 9'($random(seed)), 8'($random(seed)));
    $display("test decrement done");
    instr = OPC_WDT_CLEAR;
    instr_valid = 1;
    @(negedge clk);
    instr_valid = 0;
    `CHK("wdt_clear", 1'b1, wdt_clear_q)
    `CHK("zero", zf, zero_flag_q)
    @(negedge clk);
    `CHK("wdt_clear", 1'b0, wdt_clear_q)
    $display("test watchdog done");
    // With the enable low the decrement must be ignored entirely.
    ce = 0;
    rf.mem[9'h020] = 8'h05;
    instr = {OPC_DEC, 9'h020};
    instr_valid = 1;
    @(negedge clk);
    ce = 1;
    instr_valid = 0;
    `CHK("frozen_we", 1'b0, reg_we_q)
    `CHK("frozen_zero", zf, zero_flag_q)
    @(negedge clk);
    `CHK("frozen_reg", 8'h05, rf.mem[9'h020])
    $display("test enable done");
    // Flash ops are only issued once the pending flag is low, as code in RAM must.
    ad = {8'h01, 16'($random(seed)) & 16'hfffe};
    d = 16'($random(seed));
    fl(OPC_FLASH_PROG, ad, d);
    fl(OPC_FLASH_READ, ad, 16'h0000);
    `CHK("rdata", d, data_out_q)
    fl(OPC_FLASH_ERASE, {ad[23:8], 8'h00}, 16'h0000);
    fl(OPC_FLASH_READ, ad, 16'h0000);
    `CHK("erased", ERASED_WORD, data_out_q)
    fl(OPC_FLASH_PROG, {8'h02, ad[15:0]}, d);
    fl(OPC_FLASH_READ, ad, 16'h0000);
    `CHK("outside", ERASED_WORD, data_out_q)
    $display("test flash done");
    close_out();
  end
endmodule
`default_nettype wire
